// ==== rtl/burst_seq.sv ====
`timescale 1ns/100ps
module burst_seq
  import burst_sram_pkg::*;
(
  // burst seed and position
  input wire logic [burst_sram_pkg::BURST_W-1:0] i_start,
  input wire logic [burst_sram_pkg::BURST_W-1:0] i_step,
  input wire logic i_linear,
  // resulting low address
  output logic [burst_sram_pkg::BURST_W-1:0] o_burst_low_addr
);

  // linear wraps modulo four by the width of the sum; interleaved is start xor step
  always_comb begin
    if (i_linear) begin
      o_burst_low_addr = i_start + i_step;
    end else begin
      o_burst_low_addr = i_start ^ i_step;
    end
  end

endmodule : burst_seq

// ==== rtl/burst_sram_ctrl.sv ====
`timescale 1ns/100ps
module burst_sram_ctrl
  import burst_sram_pkg::*;
#(
  parameter int NUM_LANES = burst_sram_pkg::LANES_X36,
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_X36
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // synchronous bus
  input wire burst_sram_pkg::bus_ctrl_t i_ctrl,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [NUM_LANES-1:0] i_lane_write_n,
  input wire logic i_seq_interleave,
  // asynchronous controls
  input wire logic i_output_enable_n,
  input wire logic i_snooze_req,
  // data lanes, parity in the top bit of each lane
  input wire logic [NUM_LANES*burst_sram_pkg::LANE_W-1:0] i_data_lanes,
  output logic [NUM_LANES*burst_sram_pkg::LANE_W-1:0] o_data_lanes,
  output logic o_data_lanes_oe,
  // status
  output logic o_power_down
);

  localparam int DATA_W = NUM_LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic run;
  logic chip_sel;
  logic write_req;
  logic [NUM_LANES-1:0] lane_wr;
  cycle_op_t op;
  logic [ADDR_W-1:0] access_addr;
  logic [BURST_W-1:0] seq_low;
  logic [BURST_W-1:0] step_next;
  logic proc_start;
  logic desel;
  wire logic [DATA_W-1:0] rd_word;

  logic active_q, active_d;
  logic write_q, write_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic [BURST_W-1:0] step_q, step_d;
  logic rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic rd_valid_q, rd_valid_d;
  logic dsel_q, dsel_d;
  logic [DATA_W-1:0] dout_q, dout_d;

  // storage is split per lane below so each lane's write process owns its own array

  // snooze stalls the clocked logic like a dropped enable
  assign run = i_ce & ~i_snooze_req;
  assign chip_sel = ~i_ctrl.chip_sel1_n & i_ctrl.chip_sel2 & ~i_ctrl.chip_sel3_n;
  // the first enable alone hides the processor strobe, so it never counts as a deselect there
  assign proc_start = ~i_ctrl.processor_addr_strobe_n & ~i_ctrl.chip_sel1_n;
  assign desel = (proc_start | ~i_ctrl.controller_addr_strobe_n) & ~chip_sel;

  always_comb begin
    write_req = ~i_ctrl.all_lanes_write_n
      | (~i_ctrl.byte_write_gate_n & ~(&i_lane_write_n));
    if (!i_ctrl.all_lanes_write_n) begin
      lane_wr = '1;
    end else if (!i_ctrl.byte_write_gate_n) begin
      lane_wr = ~i_lane_write_n;
    end else begin
      lane_wr = '0;
    end
  end

  always_comb begin
    // a deselected first enable hides the processor strobe
    if (proc_start) begin
      op = chip_sel ? OP_BEGIN : OP_IDLE;
    end else if (!i_ctrl.controller_addr_strobe_n) begin
      op = chip_sel ? OP_BEGIN : OP_IDLE;
    end else if (!active_q) begin
      op = OP_IDLE;
    end else if (!i_ctrl.burst_advance_n) begin
      op = OP_CONTINUE;
    end else begin
      op = OP_SUSPEND;
    end
  end

  // next burst step kept apart from the state process so the sequencer sees no loop
  assign step_next = (op == OP_CONTINUE) ? step_q + STEP_ONE : step_q;

  burst_seq u_seq (
    .i_start(base_q[BURST_W-1:0]),
    .i_step(step_next),
    .i_linear(~i_seq_interleave),
    .o_burst_low_addr(seq_low)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // burst state

  always_comb begin
    active_d = active_q;
    write_d = 1'b0;
    base_d = base_q;
    step_d = step_q;
    rd_pend_d = 1'b0;
    rd_addr_d = rd_addr_q;
    dsel_d = dsel_q;
    access_addr = {base_q[ADDR_W-1:BURST_W], seq_low};
    case (op)
      OP_BEGIN: begin
        active_d = 1'b1;
        base_d = i_addr;
        step_d = STEP_ZERO;
        access_addr = i_addr;
        dsel_d = 1'b0;
        // processor strobe always reads first; writes come at the next edge
        write_d = i_ctrl.processor_addr_strobe_n & write_req;
      end
      OP_CONTINUE: begin
        step_d = step_next;
        write_d = write_req;
      end
      OP_SUSPEND: begin
        write_d = write_req;
      end
      OP_IDLE: begin
        if (desel) begin
          active_d = 1'b0;
          dsel_d = 1'b1;
        end
      end
      default: begin
        active_d = 1'b0;
      end
    endcase
    if (op != OP_IDLE && !write_d) begin
      rd_pend_d = 1'b1;
      rd_addr_d = access_addr;
    end
    if (op == OP_BEGIN && !write_d) begin
      rd_pend_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read pipeline: array read one edge after the access is registered

  always_comb begin
    rd_valid_d = rd_pend_q;
    dout_d = rd_pend_q ? rd_word : dout_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_q <= 1'b0;
      write_q <= 1'b0;
      base_q <= '0;
      step_q <= STEP_ZERO;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
      rd_valid_q <= 1'b0;
      dsel_q <= 1'b1;
      dout_q <= '0;
    end else if (run) begin
      active_q <= active_d;
      write_q <= write_d;
      base_q <= base_d;
      step_q <= step_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rd_valid_q <= rd_valid_d;
      dsel_q <= dsel_d;
      dout_q <= dout_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array write, one generate branch per lane

  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [DEPTH];
    // the read port sees the old word when a write hits the same address
    assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_addr_q];
    always_ff @(posedge i_clk) begin
      if (run && write_d && lane_wr[g]) begin
        lane_mem[access_addr] <= i_data_lanes[g*LANE_W +: LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins: output enable gates the drivers with no clock in the path

  // snooze drops the drivers at once, without waiting for a clock
  assign o_data_lanes = dout_q;
  assign o_data_lanes_oe = rd_valid_q & ~write_q & ~i_output_enable_n & ~i_snooze_req;
  assign o_power_down = i_snooze_req | dsel_q;

endmodule : burst_sram_ctrl

// ==== rtl/burst_sram_pkg.sv ====
package burst_sram_pkg;

  localparam int BURST_W = 2;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = LANE_DATA_W + 1;
  localparam int LANES_X36 = 4;
  localparam int LANES_X18 = 2;
  localparam int ADDR_W_X36 = 19;
  localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

  // synchronous control pins, all active levels as on the bus
  typedef struct packed {
    logic chip_sel1_n;
    logic chip_sel2;
    logic chip_sel3_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic all_lanes_write_n;
    logic byte_write_gate_n;
  } bus_ctrl_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_BEGIN,
    OP_CONTINUE,
    OP_SUSPEND
  } cycle_op_t;

endpackage : burst_sram_pkg

// ==== verification/burst_sram_asserts.sv ====
`timescale 1ns/100ps
module burst_sram_asserts
  import burst_sram_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire burst_sram_pkg::bus_ctrl_t i_ctrl,
  input wire logic i_output_enable_n,
  input wire logic i_snooze_req,
  input wire logic o_data_lanes_oe,
  input wire logic o_power_down
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic go, en, sp, sc, qt;
  assign go = i_ce && !i_snooze_req;
  assign en = !i_ctrl.chip_sel1_n && i_ctrl.chip_sel2 && !i_ctrl.chip_sel3_n;
  assign sp = go && !i_ctrl.processor_addr_strobe_n && !i_ctrl.chip_sel1_n;
  assign sc = go && i_ctrl.processor_addr_strobe_n && !i_ctrl.controller_addr_strobe_n;
  assign qt = go && i_ctrl.processor_addr_strobe_n && i_ctrl.controller_addr_strobe_n
    && i_ctrl.all_lanes_write_n && i_ctrl.byte_write_gate_n;
  // two quiet cycles let the pipelined read reach the pins
  sequence quiet_shown;
    qt ##1 qt ##1 (!i_output_enable_n && !i_snooze_req);
  endsequence
  AST_READ_OE: assert property ((sp && en) ##1 quiet_shown |-> o_data_lanes_oe)
    else $error("read data not driven");
  AST_OE_PIN: assert property (i_output_enable_n |-> !o_data_lanes_oe)
    else $error("driven with output enable high");
  AST_SNOOZE: assert property (i_snooze_req [*2] |-> o_power_down && !o_data_lanes_oe)
    else $error("snooze not honoured");
  AST_DESEL_C: assert property (sc && i_ctrl.chip_sel1_n |=> o_power_down)
    else $error("deselect missed");
  AST_DESEL_P: assert property (sp && !en |=> o_power_down)
    else $error("deselect missed");
  AST_WAKE: assert property ((sp || sc) && en |=> !o_power_down || i_snooze_req)
    else $error("begin left power down");
  AST_WR_HIZ: assert property (sc && en && !i_ctrl.all_lanes_write_n |=> !o_data_lanes_oe)
    else $error("driven after write");
  AST_PWRUP: assert property ($rose(i_rst_b) |-> !o_data_lanes_oe)
    else $error("driven at power up");
endmodule : burst_sram_asserts
////////////////////////////////////////////////////////////////////////////////
bind burst_sram_ctrl burst_sram_asserts burst_sram_asserts_i (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_ctrl(i_ctrl), .i_output_enable_n(i_output_enable_n),
  .i_snooze_req(i_snooze_req), .o_data_lanes_oe(o_data_lanes_oe),
  .o_power_down(o_power_down));

// ==== verification/bus_master_model.sv ====
`timescale 1ns/100ps
module bus_master_model
  import burst_sram_pkg::*;
(
  output burst_sram_pkg::bus_ctrl_t o_ctrl,
  output logic [5:0] o_addr,
  output logic [1:0] o_lane_write_n,
  output logic [17:0] o_data,
  output logic o_output_enable_n
);
  initial begin
    o_data = 18'h0;
    drive(8'h5F, 6'h00, 2'h3, 18'h0, 1'b1);
  end
  task automatic drive(input bus_ctrl_t c, input logic [5:0] a, input logic [1:0] l,
      input logic [17:0] d, input logic h);
    o_ctrl = c;
    o_addr = a;
    o_lane_write_n = l;
    // writes keep output enable high so both sides never fight on the pins
    o_output_enable_n = h || !c.all_lanes_write_n || !c.byte_write_gate_n;
    o_data = (c.all_lanes_write_n && c.byte_write_gate_n) ? ~o_data : d;
  endtask : drive
endmodule : bus_master_model

// ==== verification/tb.sv ====
`timescale 1ns/100ps
module tb;
  import burst_sram_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic seq = 1'b1;
  logic zz = 1'b0;
  logic ce = 1'b1;
  bus_ctrl_t ctrl;
  logic [5:0] addr;
  logic [1:0] lwn;
  logic [17:0] din, dout;
  logic oe_n, doe, pd;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  bus_master_model bus_master_model_i (.o_ctrl(ctrl), .o_addr(addr), .o_lane_write_n(lwn),
    .o_data(din), .o_output_enable_n(oe_n));
  burst_sram_ctrl #(.NUM_LANES(2), .ADDR_W(6)) burst_sram_ctrl_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ce(ce), .i_ctrl(ctrl), .i_addr(addr), .i_lane_write_n(lwn),
    .i_seq_interleave(seq), .i_output_enable_n(oe_n), .i_snooze_req(zz),
    .i_data_lanes(din), .o_data_lanes(dout), .o_data_lanes_oe(doe), .o_power_down(pd));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic t_burst();
    bus_ctrl_t c;
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk);
      seq = (i < 4);
      if (i < 4) begin
        c = (i == 0) ? 8'h55 : 8'h59;
        bus_master_model_i.drive(c, 6'h05, 2'h3, 18'h20100 | 18'(i), 1'b0);
      end else begin
        c = (i == 4) ? 8'h4F : ((i < 8) ? 8'h5B : 8'h5F);
        bus_master_model_i.drive(c, 6'h04, 2'h3, 18'h0, 1'b0);
      end
      // an access shows its data two edges after it is taken: reads from i = 4 appear at i = 6
      if (i >= 6) begin
        chk("burst data", 18'h20100 | 18'((i - 6) ^ 1), dout);
        chk("burst oe", 18'h1, 18'(doe));
      end
    end
  endtask : t_burst
  task automatic t_lanes();
    @(negedge i_clk);
    bus_master_model_i.drive(8'h56, 6'h09, 2'h2, 18'h3FFFF, 1'b0);
    @(negedge i_clk);
    bus_master_model_i.drive(8'h5E, 6'h09, 2'h1, 18'h00000, 1'b0);
    @(negedge i_clk);
    bus_master_model_i.drive(8'h4F, 6'h09, 2'h3, 18'h0, 1'b1);
    repeat (3) @(negedge i_clk);
    chk("hidden oe", 18'h0, 18'(doe));
    bus_master_model_i.drive(8'h5F, 6'h09, 2'h3, 18'h0, 1'b0);
    #1 chk("lane data", 18'h001FF, dout);
    chk("oe follows pin", 18'h1, 18'(doe));
  endtask : t_lanes
  task automatic t_proc_write();
    @(negedge i_clk);
    bus_master_model_i.drive(8'h4D, 6'h09, 2'h3, 18'h00000, 1'b0);
    @(negedge i_clk);
    bus_master_model_i.drive(8'h5E, 6'h09, 2'h1, 18'h2AA00, 1'b0);
    @(negedge i_clk);
    bus_master_model_i.drive(8'h4F, 6'h09, 2'h3, 18'h0, 1'b0);
    @(negedge i_clk);
    bus_master_model_i.drive(8'h5F, 6'h09, 2'h3, 18'h0, 1'b0);
    @(negedge i_clk);
    chk("strobe write", 18'h2ABFF, dout);
    chk("strobe oe", 18'h1, 18'(doe));
  endtask : t_proc_write
  task automatic t_idle();
    @(negedge i_clk);
    bus_master_model_i.drive(8'hD7, 6'h00, 2'h3, 18'h0, 1'b0);
    @(negedge i_clk);
    chk("deselect pd", 18'h1, 18'(pd));
    zz = 1'b1;
    bus_master_model_i.drive(8'h4F, 6'h01, 2'h3, 18'h0, 1'b0);
    repeat (2) @(negedge i_clk);
    chk("snooze oe", 18'h0, 18'(doe));
    zz = 1'b0;
    bus_master_model_i.drive(8'h5F, 6'h01, 2'h3, 18'h0, 1'b0);
    @(negedge i_clk);
    chk("snooze pd", 18'h1, 18'(pd));
    ce = 1'b0;
    bus_master_model_i.drive(8'h4F, 6'h01, 2'h3, 18'h0, 1'b0);
    @(negedge i_clk);
    chk("frozen pd", 18'h1, 18'(pd));
    ce = 1'b1;
    @(negedge i_clk);
    chk("wake pd", 18'h0, 18'(pd));
  endtask : t_idle
  task automatic complete_run();
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_b = 1'b1;
    chk("power-up oe", 18'h0, 18'(doe));
    t_burst();
    t_lanes();
    t_proc_write();
    t_idle();
    complete_run();
  end
endmodule : tb
